/* File: verilog/ahs_pkg.sv */
// Package of constants and types for the axis homing sequencer
`default_nettype none
package ahs_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] AHS_CTRL_OFS   = 8'h00;
  localparam logic [7:0] AHS_POL_OFS    = 8'h04;
  localparam logic [7:0] AHS_LOWVEL_OFS = 8'h08;
  localparam logic [7:0] AHS_STAT_OFS   = 8'h0C;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int AHS_CTRL_START = 0;
  localparam int AHS_CTRL_DIR   = 1;
  localparam int AHS_CTRL_ABORT = 2;
  localparam int AHS_CTRL_MODE  = 4;
  localparam int AHS_CTRL_HRST  = 8;
  localparam int AHS_ST_BUSY    = 0;
  localparam int AHS_ST_DONE    = 1;
  localparam int AHS_ST_ERR     = 2;
  localparam int AHS_ST_IN      = 4;
  localparam int AHS_ST_PHASE   = 8;
  localparam int AHS_ST_DIR     = 12;
  localparam logic [31:0] AHS_LOWVEL_RST = 32'h0000_0000;
  // ----------------------------------------
  // Home modes
  // ----------------------------------------
  typedef enum logic [3:0] {
    AHS_M_OI   = 4'h3, // origin_then_index
    AHS_M_ORI  = 4'h4, // origin_then_reverse_index
    AHS_M_LRI  = 4'h5, // limit_then_reverse_index
    AHS_M_OS   = 4'h6, // origin_search
    AHS_M_LS   = 4'h7, // limit_search
    AHS_M_OSI  = 4'h8, // origin_search_then_index
    AHS_M_OSRI = 4'h9, // origin_search_then_reverse_index
    AHS_M_LSRI = 4'hA, // limit_search_then_reverse_index
    AHS_M_OSRF = 4'hB  // origin_search_refind
  } ahs_mode_t;
  // ----------------------------------------
  // Sequencer states and motion phases
  // ----------------------------------------
  typedef enum logic [1:0] {
    AHS_S_IDLE  = 2'h0,
    AHS_S_RUN   = 2'h1,
    AHS_S_BRAKE = 2'h2
  } ahs_state_t;
  typedef enum logic [3:0] {
    AHS_P_LEAVE_ORG = 4'h0,
    AHS_P_LEAVE_IDX = 4'h1,
    AHS_P_LEAVE_LIM = 4'h2,
    AHS_P_SEEK_ORG  = 4'h3,
    AHS_P_SEEK_LIM  = 4'h4,
    AHS_P_PASS_IN   = 4'h5,
    AHS_P_PASS_OUT  = 4'h6,
    AHS_P_SEEK_IDX  = 4'h7,
    AHS_P_REF_LEAVE = 4'h8,
    AHS_P_REF_SEEK  = 4'h9
  } ahs_phase_t;
endpackage
`default_nettype wire

/* File: verilog/ahs_homing.sv */
// Homing sequencer for one axis with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Outside fields: seek origin, then index, stop
// - In origin: leave, reseek origin, stop index
// - In index: leave, seek origin, stop index
// - Limit aborts origin-plus-index home modes
// - Origin stop, reverse, stop on index
// - Leave field first, reverse at origin
// - Limit stop, reverse, stop on index
// - Starting in limit: reverse at once
// - In index: leave, reverse at limit
// - Origin search stops on origin rise
// - In origin: back out, reverse, reseek
// - Limit first: pass origin, reverse, reseek
// - Limit search stops on limit rise
// - In limit: back out, reverse, reseek
// - Origin search, then same-direction index
// - Limit first: pass origin, then index
// - Origin search, reverse, stop on index
// - Limit search, reverse, stop on index
// - Refind origin at low velocity after search
// - Keep direction from origin to index
// - Home reset option clears position counters
module ahs_homing (
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Axis sensors
  input  wire logic        origin,
  input  wire logic        end_limit,
  input  wire logic        index_pulse,
  // Trajectory logic
  input  wire logic        axis_idle,
  output logic             move_run,
  output logic             move_dir,
  output logic             move_low,
  output logic      [31:0] low_velocity,
  output logic             pos_clear
);
  import ahs_pkg::*;

  // ----------------------------------------
  // Registers and bus state
  // ----------------------------------------
  logic        dp_wr;
  logic [7:0]  dp_addr;
  logic        ctrl_dir;
  logic [3:0]  ctrl_mode;
  logic        home_reset_option;
  logic [2:0]  pol_low;
  logic        start_req;
  logic        abort_req;
  logic        done_flag;
  logic        err_flag;
  logic        set_done;
  logic        set_err;
  logic [31:0] next_rdata;
  logic        wr_ctrl;
  logic        wr_stat;

  // Slave is always ready and always answers OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else if (hready) begin
      dp_wr   <= hsel & htrans[1] & hwrite;
      dp_addr <= haddr[7:0];
    end
  end

  assign wr_ctrl = dp_wr && dp_addr == AHS_CTRL_OFS;
  assign wr_stat = dp_wr && dp_addr == AHS_STAT_OFS;

  // ----------------------------------------
  // Input normalisation and edges
  // ----------------------------------------
  logic [2:0] norm_in;
  logic [2:0] prev_in;
  logic       org_rise;
  logic       org_fall;
  logic       lim_rise;
  logic       lim_fall;
  logic       idx_rise;
  logic       idx_fall;

  assign norm_in = {index_pulse, end_limit, origin} ^ pol_low;

  // Previous levels for edge detection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) prev_in <= 3'h0;
    else          prev_in <= norm_in;
  end

  assign org_rise = norm_in[0] & ~prev_in[0];
  assign org_fall = ~norm_in[0] & prev_in[0];
  assign lim_rise = norm_in[1] & ~prev_in[1];
  assign lim_fall = ~norm_in[1] & prev_in[1];
  assign idx_rise = norm_in[2] & ~prev_in[2];
  assign idx_fall = ~norm_in[2] & prev_in[2];

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_dir          <= 1'b0;
      ctrl_mode         <= 4'h0;
      home_reset_option <= 1'b0;
      pol_low           <= 3'h0;
      low_velocity      <= AHS_LOWVEL_RST;
      start_req         <= 1'b0;
      abort_req         <= 1'b0;
    end else begin
      start_req <= wr_ctrl & hwdata[AHS_CTRL_START];
      abort_req <= wr_ctrl & hwdata[AHS_CTRL_ABORT];
      if (wr_ctrl) begin
        ctrl_dir          <= hwdata[AHS_CTRL_DIR];
        ctrl_mode         <= hwdata[AHS_CTRL_MODE +: 4];
        home_reset_option <= hwdata[AHS_CTRL_HRST];
      end
      if (dp_wr && dp_addr == AHS_POL_OFS) pol_low <= hwdata[2:0];
      if (dp_wr && dp_addr == AHS_LOWVEL_OFS) low_velocity <= hwdata;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  ahs_state_t state;
  ahs_phase_t phase;
  ahs_mode_t  mode;
  ahs_phase_t act_next;
  logic       act_hit;
  logic       act_rev;
  logic       act_fin;
  logic       act_err;
  logic       pend_rev;
  logic       pend_fin;
  logic       pend_err;
  logic       mode_ok;
  logic       org_search;

  assign mode_ok = ctrl_mode >= AHS_M_OI && ctrl_mode <= AHS_M_OSRF;
  assign org_search = mode == AHS_M_OS || mode == AHS_M_OSI
                   || mode == AHS_M_OSRI || mode == AHS_M_OSRF;
  // Index and refind stages run at the low velocity
  assign move_low = phase == AHS_P_SEEK_IDX || phase == AHS_P_LEAVE_IDX
                 || phase == AHS_P_REF_LEAVE || phase == AHS_P_REF_SEEK;

  // Reaction to the sensor events in the current phase
  always_comb begin
    act_hit  = 1'b0;
    act_rev  = 1'b0;
    act_fin  = 1'b0;
    act_err  = 1'b0;
    act_next = phase;
    if (lim_rise && phase != AHS_P_SEEK_LIM) begin
      act_hit = 1'b1;
      if (org_search && phase == AHS_P_SEEK_ORG) begin
        act_rev  = 1'b1;
        act_next = AHS_P_PASS_IN;
      end else begin
        act_fin = 1'b1;
        act_err = 1'b1;
      end
    end else begin
      case (phase)
        AHS_P_LEAVE_ORG: if (org_fall) begin
          act_hit  = 1'b1;
          act_rev  = org_search;
          act_next = AHS_P_SEEK_ORG;
        end
        AHS_P_LEAVE_IDX: if (idx_fall) begin
          act_hit  = 1'b1;
          act_next = (mode == AHS_M_LRI) ? AHS_P_SEEK_LIM : AHS_P_SEEK_ORG;
        end
        AHS_P_LEAVE_LIM: if (lim_fall) begin
          act_hit  = 1'b1;
          act_rev  = 1'b1;
          act_next = AHS_P_SEEK_LIM;
        end
        AHS_P_SEEK_ORG: if (org_rise) begin
          act_hit  = 1'b1;
          act_next = AHS_P_SEEK_IDX;
          case (mode)
            AHS_M_ORI, AHS_M_OSRI: act_rev = 1'b1;
            AHS_M_OS: act_fin = 1'b1;
            AHS_M_OSRF: begin
              act_rev  = 1'b1;
              act_next = AHS_P_REF_LEAVE;
            end
            default: act_rev = 1'b0;
          endcase
        end
        AHS_P_SEEK_LIM: if (lim_rise) begin
          act_hit  = 1'b1;
          act_fin  = mode == AHS_M_LS;
          act_rev  = mode != AHS_M_LS;
          act_next = AHS_P_SEEK_IDX;
        end
        AHS_P_PASS_IN: if (org_rise) begin
          act_hit  = 1'b1;
          act_next = AHS_P_PASS_OUT;
        end
        AHS_P_PASS_OUT: if (org_fall) begin
          act_hit  = 1'b1;
          act_rev  = 1'b1;
          act_next = AHS_P_SEEK_ORG;
        end
        AHS_P_SEEK_IDX: if (idx_rise) begin
          act_hit = 1'b1;
          act_fin = 1'b1;
        end
        AHS_P_REF_LEAVE: if (org_fall) begin
          act_hit  = 1'b1;
          act_rev  = 1'b1;
          act_next = AHS_P_REF_SEEK;
        end
        AHS_P_REF_SEEK: if (org_rise) begin
          act_hit = 1'b1;
          act_fin = 1'b1;
        end
        default: act_hit = 1'b0;
      endcase
    end
  end

  // Motion control: start, phase steps, braking and completion
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= AHS_S_IDLE;
      phase     <= AHS_P_SEEK_ORG;
      mode      <= AHS_M_OI;
      move_run  <= 1'b0;
      move_dir  <= 1'b0;
      pend_rev  <= 1'b0;
      pend_fin  <= 1'b0;
      pend_err  <= 1'b0;
      set_done  <= 1'b0;
      set_err   <= 1'b0;
      pos_clear <= 1'b0;
    end else begin
      set_done  <= 1'b0;
      set_err   <= 1'b0;
      pos_clear <= 1'b0;
      case (state)
        AHS_S_IDLE: if (start_req) begin
          if (!mode_ok) begin
            set_err <= 1'b1;
          end else begin
            state    <= AHS_S_RUN;
            move_run <= 1'b1;
            mode     <= ahs_mode_t'(ctrl_mode);
            move_dir <= ctrl_dir;
            case (ahs_mode_t'(ctrl_mode))
              AHS_M_OI, AHS_M_ORI:
                phase <= norm_in[0] ? AHS_P_LEAVE_ORG :
                         norm_in[2] ? AHS_P_LEAVE_IDX : AHS_P_SEEK_ORG;
              AHS_M_LRI: begin
                if (norm_in[1]) begin
                  move_dir <= ~ctrl_dir;
                  phase    <= AHS_P_SEEK_IDX;
                end else begin
                  phase <= norm_in[2] ? AHS_P_LEAVE_IDX : AHS_P_SEEK_LIM;
                end
              end
              AHS_M_LS, AHS_M_LSRI: begin
                move_dir <= ctrl_dir ^ norm_in[1];
                phase    <= norm_in[1] ? AHS_P_LEAVE_LIM : AHS_P_SEEK_LIM;
              end
              default: begin
                move_dir <= ctrl_dir ^ norm_in[0];
                phase    <= norm_in[0] ? AHS_P_LEAVE_ORG : AHS_P_SEEK_ORG;
              end
            endcase
          end
        end
        AHS_S_RUN: begin
          if (abort_req) begin
            state    <= AHS_S_BRAKE;
            move_run <= 1'b0;
            pend_fin <= 1'b1;
            pend_err <= 1'b1;
            pend_rev <= 1'b0;
          end else if (act_hit) begin
            phase <= act_next;
            if (act_rev || act_fin) begin
              state    <= AHS_S_BRAKE;
              move_run <= 1'b0;
              pend_rev <= act_rev;
              pend_fin <= act_fin;
              pend_err <= act_err;
            end
          end
        end
        AHS_S_BRAKE: if (axis_idle) begin
          if (pend_fin) begin
            state     <= AHS_S_IDLE;
            set_done  <= 1'b1;
            set_err   <= pend_err;
            pos_clear <= home_reset_option;
          end else begin
            state    <= AHS_S_RUN;
            move_run <= 1'b1;
            move_dir <= move_dir ^ pend_rev;
          end
        end
        default: state <= AHS_S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Status flags and read data
  // ----------------------------------------
  // Sticky flags: a set in the clearing cycle wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_flag <= 1'b0;
      err_flag  <= 1'b0;
    end else begin
      if (set_done) done_flag <= 1'b1;
      else if (wr_stat && hwdata[AHS_ST_DONE]) done_flag <= 1'b0;
      if (set_err) err_flag <= 1'b1;
      else if (wr_stat && hwdata[AHS_ST_ERR]) err_flag <= 1'b0;
    end
  end

  // Read multiplexer, registered into the data phase
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (haddr[7:0])
      AHS_CTRL_OFS: begin
        next_rdata[AHS_CTRL_DIR]        = ctrl_dir;
        next_rdata[AHS_CTRL_MODE +: 4]  = ctrl_mode;
        next_rdata[AHS_CTRL_HRST]       = home_reset_option;
      end
      AHS_POL_OFS:    next_rdata[2:0] = pol_low;
      AHS_LOWVEL_OFS: next_rdata = low_velocity;
      AHS_STAT_OFS: begin
        next_rdata[AHS_ST_BUSY]        = state != AHS_S_IDLE;
        next_rdata[AHS_ST_DONE]        = done_flag;
        next_rdata[AHS_ST_ERR]         = err_flag;
        next_rdata[AHS_ST_IN +: 3]     = norm_in;
        next_rdata[AHS_ST_PHASE +: 4]  = phase;
        next_rdata[AHS_ST_DIR]         = move_dir;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else if (hready && hsel && htrans[1] && !hwrite) hrdata <= next_rdata;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_rev_hit;
    state == AHS_S_RUN && !abort_req && act_hit && act_rev;
  endsequence
  sequence s_finish;
    state == AHS_S_BRAKE && pend_fin && axis_idle;
  endsequence

  a_brake_on_rev: assert property (s_rev_hit |=> state == AHS_S_BRAKE && !move_run)
    else $error("reversal without stop");
  a_flip_after_brake: assert property (state == AHS_S_BRAKE && axis_idle && !pend_fin
    |=> move_run && move_dir != $past(move_dir))
    else $error("direction not reversed after stop");
  a_limit_abort: assert property (state == AHS_S_RUN && !abort_req && lim_rise
    && (mode == AHS_M_OI || mode == AHS_M_ORI) |=> !move_run ##0 pend_err)
    else $error("limit did not abort home");
  a_index_stop: assert property (state == AHS_S_RUN && !abort_req && !lim_rise
    && phase == AHS_P_SEEK_IDX && idx_rise |=> !move_run ##0 pend_fin)
    else $error("index did not stop the axis");
  a_same_dir: assert property (state == AHS_S_RUN && !abort_req && !lim_rise
    && mode == AHS_M_OI && phase == AHS_P_SEEK_ORG && org_rise
    |=> move_run && phase == AHS_P_SEEK_IDX && $stable(move_dir))
    else $error("direction changed between origin and index");
  a_pos_clear: assert property (pos_clear |-> set_done && home_reset_option)
    else $error("position clear outside completion");
  a_norm_level: assert property ($stable(pol_low) && $rose(end_limit ^ pol_low[1]) |-> lim_rise)
    else $error("normalised limit edge not detected");
  a_start_in_lim: assert property (state == AHS_S_IDLE && start_req && ctrl_mode == AHS_M_LRI
    && norm_in[1] |=> move_run && phase == AHS_P_SEEK_IDX && move_dir != ctrl_dir)
    else $error("start inside limit did not reverse");
  a_done_report: assert property (s_finish |=> state == AHS_S_IDLE ##1 done_flag)
    else $error("completion not reported");
endmodule // ahs_homing
`default_nettype wire

/* File: bench/ahs_axis_model.sv */
// Behavioural axis with origin, limit and index sensors and a braking trajectory
`timescale 1ns/1ps
`default_nettype none
module ahs_axis_model (
  // Clock and reset
  input  wire logic               hclk,
  input  wire logic               hresetn,
  // Motion request from the sequencer
  input  wire logic               move_run,
  input  wire logic               move_dir,
  input  wire logic               move_low,
  input  wire logic               pos_clear,
  // Bench controls
  input  wire logic [2:0]         pol,
  input  wire logic               load,
  input  wire logic signed [31:0] load_pos,
  // Sensor levels and observations
  output logic                    origin,
  output logic                    end_limit,
  output logic                    index_pulse,
  output logic                    axis_idle,
  output logic signed [31:0]      pos,
  output logic [7:0]              n_clear,
  output logic                    low_seen
);
  logic [2:0]         step_cnt;
  logic [1:0]         brake_cnt;
  logic signed [31:0] idx_mod;
  // Sensor fields; a set pol bit makes that raw line active low
  assign idx_mod     = ((pos % 20) + 20) % 20;
  assign origin      = ((pos >= 40 && pos <= 49) || (pos >= -60 && pos <= -51)) ^ pol[0];
  assign end_limit   = (pos >= 100 || pos <= -100) ^ pol[1];
  assign index_pulse = (idx_mod == 15) ^ pol[2];
  // One count every eight cycles, so a stop lands before the next count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos      <= 0;
      step_cnt <= 3'h0;
      low_seen <= 1'b0;
    end else if (load) begin
      pos      <= load_pos;
      step_cnt <= 3'h0;
      low_seen <= 1'b0;
    end else if (move_run) begin
      step_cnt <= step_cnt + 3'h1;
      if (step_cnt == 3'h7) begin
        pos      <= move_dir ? pos - 1 : pos + 1;
        low_seen <= low_seen | move_low;
      end
    end else begin
      step_cnt <= 3'h0;
    end
  end
  // Braking takes four cycles before the axis reports standstill
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      axis_idle <= 1'b1;
      brake_cnt <= 2'h0;
    end else if (move_run) begin
      axis_idle <= 1'b0;
      brake_cnt <= 2'h0;
    end else if (!axis_idle) begin
      brake_cnt <= brake_cnt + 2'h1;
      axis_idle <= (brake_cnt == 2'h3);
    end
  end
  // Position counter clear requests
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_clear <= 8'h00;
    end else if (load) begin
      n_clear <= 8'h00;
    end else if (pos_clear) begin
      n_clear <= n_clear + 8'h01;
    end
  end
endmodule // ahs_axis_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench: register access and home sequences against the axis model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ahs_pkg::*;
  logic               hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0]        haddr, hwdata, hrdata, low_velocity, rd;
  logic [1:0]         htrans;
  logic [2:0]         hsize, pol;
  logic               origin, end_limit, index_pulse, axis_idle;
  logic               move_run, move_dir, move_low, pos_clear, load, low_seen;
  logic signed [31:0] load_pos, pos;
  logic [7:0]         n_clear;
  int                 n_mismatch, comparisons;

  ahs_homing u_ahs_homing (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .origin(origin),
    .end_limit(end_limit), .index_pulse(index_pulse), .axis_idle(axis_idle),
    .move_run(move_run), .move_dir(move_dir), .move_low(move_low),
    .low_velocity(low_velocity), .pos_clear(pos_clear));
  ahs_axis_model u_ahs_axis_model (
    .hclk(hclk), .hresetn(hresetn), .move_run(move_run), .move_dir(move_dir),
    .move_low(move_low), .pos_clear(pos_clear), .pol(pol), .load(load),
    .load_pos(load_pos), .origin(origin), .end_limit(end_limit),
    .index_pulse(index_pulse), .axis_idle(axis_idle), .pos(pos),
    .n_clear(n_clear), .low_seen(low_seen));

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // AHB-Lite single-word master
  // ----------------------------------------
  task automatic bus_wait;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask
  task automatic ahb_write(input logic [7:0] addr, input logic [31:0] data);
    htrans <= 2'h2;
    haddr  <= {24'h0, addr};
    hwrite <= 1'b1;
    bus_wait();
    htrans <= 2'h0;
    hwdata <= data;
    bus_wait();
  endtask
  task automatic ahb_read(input logic [7:0] addr, output logic [31:0] data);
    htrans <= 2'h2;
    haddr  <= {24'h0, addr};
    hwrite <= 1'b0;
    bus_wait();
    htrans <= 2'h0;
    bus_wait();
    data = hrdata;
  endtask

  // One home command from a given spot; checks where and how the axis ended
  task automatic run_case(input logic [3:0] mode, input logic dir, input int start,
      input logic hrst, input logic [2:0] p, input int exp_pos, input logic exp_dir,
      input logic exp_err, input logic exp_low);
    logic [31:0] st;
    int          n;
    load     <= 1'b1;
    load_pos <= start;
    pol      <= p;
    @(posedge hclk);
    load <= 1'b0;
    ahb_write(AHS_POL_OFS, {29'h0, p});
    ahb_write(AHS_STAT_OFS, 32'h0000_0006);
    ahb_write(AHS_CTRL_OFS, ({31'h0, hrst} << AHS_CTRL_HRST) |
      ({28'h0, mode} << AHS_CTRL_MODE) | ({31'h0, dir} << AHS_CTRL_DIR) | 32'h1);
    n  = 0;
    st = 32'h1;
    while ((st[AHS_ST_BUSY] !== 1'b0 || (st[AHS_ST_DONE] | st[AHS_ST_ERR]) !== 1'b1)
           && n < 4000) begin
      ahb_read(AHS_STAT_OFS, st);
      n++;
    end
    if (n >= 4000) n_mismatch++;
    cmp(pos, exp_pos);
    cmp({31'h0, move_dir}, {31'h0, exp_dir});
    cmp({31'h0, st[AHS_ST_ERR]}, {31'h0, exp_err});
    cmp({24'h0, n_clear}, {31'h0, hrst});
    cmp({31'h0, low_seen}, {31'h0, exp_low});
  endtask

  // ----------------------------------------
  // Clock, watchdog and test sequence
  // ----------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (90000) @(posedge hclk);
    n_mismatch++;
    final_report();
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; pol = 3'h0; load = 1'b0; load_pos = 0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    cmp({28'h0, move_run, move_low, pos_clear, hresp}, 32'h0);
    ahb_read(AHS_POL_OFS, rd);
    cmp(rd, 32'h0);
    ahb_read(AHS_LOWVEL_OFS, rd);
    cmp(rd, AHS_LOWVEL_RST);
    ahb_read(AHS_STAT_OFS, rd);
    cmp(rd & 32'h7, 32'h0);
    ahb_write(8'h10, 32'hFFFF_FFFF);
    ahb_read(8'h10, rd);
    cmp(rd, 32'h0);
    ahb_write(AHS_LOWVEL_OFS, 32'h0000_0040);
    ahb_read(AHS_LOWVEL_OFS, rd);
    cmp(rd, 32'h0000_0040);
    cmp(low_velocity, 32'h0000_0040);
    // Mode outside the supported range is refused without motion
    run_case(4'h2, 1'b0, 0, 1'b0, 3'h0, 0, 1'b0, 1'b1, 1'b0);
    run_case(AHS_M_OI, 1'b0, 0, 1'b1, 3'h0, 55, 1'b0, 1'b0, 1'b1);
    run_case(AHS_M_OI, 1'b0, 0, 1'b0, 3'h7, 55, 1'b0, 1'b0, 1'b1);
    run_case(AHS_M_OI, 1'b1, 42, 1'b0, 3'h0, -65, 1'b1, 1'b0, 1'b1);
    run_case(AHS_M_OI, 1'b0, 15, 1'b0, 3'h0, 55, 1'b0, 1'b0, 1'b1);
    run_case(AHS_M_OI, 1'b0, 42, 1'b0, 3'h0, 100, 1'b0, 1'b1, 1'b0);
    run_case(AHS_M_ORI, 1'b0, 0, 1'b0, 3'h0, 35, 1'b1, 1'b0, 1'b1);
    run_case(AHS_M_ORI, 1'b1, 42, 1'b0, 3'h0, -45, 1'b0, 1'b0, 1'b1);
    run_case(AHS_M_LRI, 1'b0, 0, 1'b0, 3'h0, 95, 1'b1, 1'b0, 1'b1);
    run_case(AHS_M_LRI, 1'b0, 100, 1'b0, 3'h0, 95, 1'b1, 1'b0, 1'b1);
    run_case(AHS_M_LRI, 1'b0, 15, 1'b0, 3'h0, 95, 1'b1, 1'b0, 1'b1);
    run_case(AHS_M_OS, 1'b0, 0, 1'b0, 3'h0, 40, 1'b0, 1'b0, 1'b0);
    run_case(AHS_M_OS, 1'b0, 42, 1'b0, 3'h0, 40, 1'b0, 1'b0, 1'b0);
    run_case(AHS_M_OS, 1'b0, 60, 1'b0, 3'h0, 40, 1'b0, 1'b0, 1'b0);
    run_case(AHS_M_LS, 1'b0, 0, 1'b0, 3'h0, 100, 1'b0, 1'b0, 1'b0);
    run_case(AHS_M_LS, 1'b0, 102, 1'b0, 3'h0, 100, 1'b0, 1'b0, 1'b0);
    run_case(AHS_M_OSI, 1'b0, 0, 1'b0, 3'h0, 55, 1'b0, 1'b0, 1'b1);
    run_case(AHS_M_OSI, 1'b0, 60, 1'b0, 3'h0, 55, 1'b0, 1'b0, 1'b1);
    run_case(AHS_M_OSRI, 1'b0, 0, 1'b0, 3'h0, 35, 1'b1, 1'b0, 1'b1);
    run_case(AHS_M_LSRI, 1'b0, 102, 1'b0, 3'h0, 95, 1'b1, 1'b0, 1'b1);
    run_case(AHS_M_OSRF, 1'b0, 0, 1'b0, 3'h0, 40, 1'b0, 1'b0, 1'b1);
    // Software abort while seeking: axis stops, done and err both set
    load     <= 1'b1;
    load_pos <= 0;
    @(posedge hclk);
    load <= 1'b0;
    ahb_write(AHS_STAT_OFS, 32'h0000_0006);
    ahb_write(AHS_CTRL_OFS, {24'h0, AHS_M_OI, 4'h1});
    repeat (80) @(posedge hclk);
    ahb_write(AHS_CTRL_OFS, 32'h0000_0004);
    repeat (20) @(posedge hclk);
    ahb_read(AHS_STAT_OFS, rd);
    cmp(rd & 32'h7, 32'h6);
    cmp({31'h0, move_run}, 32'h0);
    cmp({31'h0, pos < 40}, 32'h1);
    final_report();
  end
endmodule // testbench
`default_nettype wire
